/* File: pkg/sds_consts.svh */
// Constants for the status display block: register map, field positions,
// reset values and timing. Assumes a 10 MHz system clock.
`ifndef SDS_CONSTS_SVH
`define SDS_CONSTS_SVH

// Register byte offsets
`define SDS_REG_CTRL 8'h00
`define SDS_REG_DWELL 8'h04
`define SDS_REG_STATUS 8'h08

// Control register bits
`define SDS_CTRL_IDENT_HOLD 0
`define SDS_CTRL_IDENT_START 1
`define SDS_CTRL_COMMISSION 2
`define SDS_CTRL_IDENT_CANCEL 3

// Status register bits
`define SDS_ST_NOT_COMM 0
`define SDS_ST_IDENT 1
`define SDS_ST_LED_GREEN 2
`define SDS_ST_LED_RED 3
`define SDS_ST_IDX_LO 8

// AXI responses
`define SDS_RESP_OKAY 2'b00
`define SDS_RESP_SLVERR 2'b10

// Timing
`define SDS_CLK_HZ 10000000
`define SDS_DWELL_MS 500
`define SDS_IDENT_STD_MS 5000
`define SDS_DWELL_CYCLES (`SDS_DWELL_MS * (`SDS_CLK_HZ / 1000))
`define SDS_IDENT_CYCLES (`SDS_IDENT_STD_MS * (`SDS_CLK_HZ / 1000))

`endif

/* File: pkg/sds_pkg.sv */
// Types shared by the status display block and its bench.
// Assumes nothing of its surroundings.
`default_nettype none
package sds_pkg;

  // Characters the single display position can show
  typedef enum logic [4:0] {
    CH_0, CH_1, CH_2, CH_3, CH_4, CH_5, CH_6, CH_7, CH_8, CH_9,
    CH_A, CH_E, CH_H, CH_L, CH_O, CH_P, CH_DASH, CH_T, CH_F, CH_D,
    CH_BLANK
  } sds_char_t;

  // Control mode of the drive
  typedef enum logic [1:0] {
    SDS_MODE_TORQUE, SDS_MODE_SPEED, SDS_MODE_POSITION
  } sds_mode_t;

  // What the display is presenting
  typedef enum logic [3:0] {
    SDS_V_IDENT, SDS_V_ERROR, SDS_V_STO, SDS_V_WARN, SDS_V_FWUPD,
    SDS_V_PFILE, SDS_V_NOTCOMM, SDS_V_HOMING, SDS_V_TORQUE,
    SDS_V_SPEED, SDS_V_POSITION
  } sds_view_t;

  // Drive state flags feeding the display
  typedef struct packed {
    sds_mode_t mode;
    logic enabled;
    logic homing;
    logic [1:0] homing_phase;
    logic fault;
    logic [3:0] err_tens;
    logic [3:0] err_ones;
    logic [3:0] err_sub;
    logic warning;
    logic [3:0] warn_tens;
    logic [3:0] warn_ones;
    logic [3:0] warn_sub;
    logic safe_torque_off_input;
    logic fw_update;
    logic parameter_set_file;
    logic ready;
    logic param_changed;
    logic [2:0] anim_step;
  } sds_drive_t;

endpackage : sds_pkg
`default_nettype wire

/* File: verilog/sds_display.sv */
// Status display block: picks what the seven-segment digit and the ready
// LED show, with an AXI4-Lite register slave for control and status.
// Assumes one 10 MHz clock and drive flags synchronous to it.
//
// Summary of operation
// [R1] Speed mode rotates one lit outer segment, stepped by the drive's motion.
// [R2] In speed mode the centre segment is also lit while the drive is enabled.
// [R3] Homing shows P, H and the phase digit 0 search, 1 crawl, 2 travel.
// [R4] Messages of several characters are shown one character at a time.
// [R5] An error shows E, two index digits, then one subindex digit.
// [R6] A warning shows hyphen, two index digits, subindex digit, hyphen.
// [R7] While a fault is present its error number is shown as a series.
// [R8] A not-commissioned flag set from delivery shows the letter A.
// [R9] The first commissioning parameter change clears that flag and the A.
// [R10] Safe torque off shows a steady indication, never blinking.
// [R11] An identify request spells HELLO on the display.
// [R12] Firmware update and parameter file loading have their own indications.
// [R13] The ready LED is green once ready and red whenever a fault is present.
// [R14] Identify may run for a standard interval or be held on and off freely.
// [R15] Priority is identify, error, safe torque off, warning, then the rest.
// [R16] Each character dwells a configurable number of cycles.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "sds_consts.svh"

module sds_display
  import sds_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [31:0] IDENT_CYCLES = 32'(`SDS_IDENT_CYCLES),
  parameter logic [31:0] DWELL_RESET = 32'(`SDS_DWELL_CYCLES)
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire sds_drive_t drive,
  input wire logic commissioned_stored,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic [6:0] seg,
  output logic led_green,
  output logic led_red
);

  // Segment pattern, bit 0 = a ... bit 6 = g
  function automatic logic [6:0] sds_glyph(input sds_char_t c);
    unique case (c)
      CH_0, CH_O: sds_glyph = 7'h3F;
      CH_1: sds_glyph = 7'h06;
      CH_2: sds_glyph = 7'h5B;
      CH_3: sds_glyph = 7'h4F;
      CH_4: sds_glyph = 7'h66;
      CH_5: sds_glyph = 7'h6D;
      CH_6: sds_glyph = 7'h7D;
      CH_7: sds_glyph = 7'h07;
      CH_8: sds_glyph = 7'h7F;
      CH_9: sds_glyph = 7'h6F;
      CH_A: sds_glyph = 7'h77;
      CH_E: sds_glyph = 7'h79;
      CH_H: sds_glyph = 7'h76;
      CH_L: sds_glyph = 7'h38;
      CH_P: sds_glyph = 7'h73;
      CH_DASH: sds_glyph = 7'h40;
      CH_T: sds_glyph = 7'h78;
      CH_F: sds_glyph = 7'h71;
      CH_D: sds_glyph = 7'h5E;
      default: sds_glyph = 7'h00;
    endcase
  endfunction : sds_glyph

  // BCD digit to character; out-of-range codes show blank
  function automatic sds_char_t sds_digit(input logic [3:0] d);
    sds_digit = (d < 4'hA) ? sds_char_t'({1'b0, d}) : CH_BLANK;
  endfunction : sds_digit

  // Bus and register state
  logic aw_have_r, aw_have_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic w_have_r, w_have_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ident_hold_r, ident_hold_nxt;
  logic [31:0] ident_cnt_r, ident_cnt_nxt;
  logic [31:0] dwell_r, dwell_nxt;
  logic not_comm_r, not_comm_nxt;
  logic strap_done_r, strap_done_nxt;

  // Display state
  sds_view_t view_r, view_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [6:0] seg_r, seg_nxt;
  logic led_green_r, led_green_nxt, led_red_r, led_red_nxt;

  logic ident_active;
  logic wr_fire;
  logic [7:0] wr_off, rd_off;

  assign ident_active = ident_hold_r || (ident_cnt_r != 32'h0000_0000);
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wr_off = 8'(aw_addr_r);
  assign rd_off = 8'(s_axi_araddr);

  // Bus slave, control register and identify timer; address and data may
  // arrive in either order and the write lands one edge after both are held
  always_comb
  begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt = w_have_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ident_hold_nxt = ident_hold_r;
    dwell_nxt = dwell_r;
    not_comm_nxt = not_comm_r;
    strap_done_nxt = 1'b1;
    ident_cnt_nxt = (ident_cnt_r != 32'h0000_0000) ?
                    ident_cnt_r - 32'h0000_0001 : ident_cnt_r; // R14
    if (s_axi_awvalid && awready_r)
    begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r)
    begin
      w_have_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (wr_fire)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `SDS_RESP_OKAY;
      if (wr_off == `SDS_REG_CTRL)
      begin
        if (w_strb_r[0])
        begin
          ident_hold_nxt = w_data_r[`SDS_CTRL_IDENT_HOLD]; // R14
          if (w_data_r[`SDS_CTRL_IDENT_START])
            ident_cnt_nxt = IDENT_CYCLES; // R14
          if (w_data_r[`SDS_CTRL_IDENT_CANCEL])
            ident_cnt_nxt = 32'h0000_0000;
          if (w_data_r[`SDS_CTRL_COMMISSION])
            not_comm_nxt = 1'b0; // R9
        end
      end
      else if (wr_off == `SDS_REG_DWELL)
      begin
        for (int b = 0; b < 4; b++)
          if (w_strb_r[b])
            dwell_nxt[8*b +: 8] = w_data_r[8*b +: 8]; // R16
      end
      else if (wr_off != `SDS_REG_STATUS)
        bresp_nxt = `SDS_RESP_SLVERR;
    end
    // Parameter change from the drive also ends delivery status
    if (drive.param_changed)
      not_comm_nxt = 1'b0; // R9
    // Stored commissioning state caught once, after reset release
    if (!strap_done_r)
      not_comm_nxt = !commissioned_stored; // R8
    if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `SDS_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (rd_off == `SDS_REG_CTRL)
        rdata_nxt[`SDS_CTRL_IDENT_HOLD] = ident_hold_r;
      else if (rd_off == `SDS_REG_DWELL)
        rdata_nxt = dwell_r;
      else if (rd_off == `SDS_REG_STATUS)
      begin
        rdata_nxt[`SDS_ST_NOT_COMM] = not_comm_r;
        rdata_nxt[`SDS_ST_IDENT] = ident_active;
        rdata_nxt[`SDS_ST_LED_GREEN] = led_green_r;
        rdata_nxt[`SDS_ST_LED_RED] = led_red_r;
        rdata_nxt[`SDS_ST_IDX_LO +: 3] = idx_r;
      end
      else
        rresp_nxt = `SDS_RESP_SLVERR;
    end
    // Readies come from flops; one write and one read in flight at most
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt = !w_have_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `SDS_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `SDS_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      ident_hold_r <= 1'b0;
      ident_cnt_r <= 32'h0000_0000;
      dwell_r <= DWELL_RESET;
      not_comm_r <= 1'b1;
      strap_done_r <= 1'b0;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r <= w_have_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ident_hold_r <= ident_hold_nxt;
      ident_cnt_r <= ident_cnt_nxt;
      dwell_r <= dwell_nxt;
      not_comm_r <= not_comm_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  // Message selection and character sequencing
  sds_char_t msg [0:5];
  logic [2:0] msg_len;
  logic [6:0] anim_seg;
  logic [31:0] dwell_eff;

  always_comb
  begin
    for (int i = 0; i < 6; i++)
      msg[i] = CH_BLANK;
    msg_len = 3'd1;
    anim_seg = 7'h00;
    // Priority chain: first matching condition owns the digit
    if (ident_active)
      view_nxt = SDS_V_IDENT; // R15
    else if (drive.fault)
      view_nxt = SDS_V_ERROR; // R15
    else if (drive.safe_torque_off_input)
      view_nxt = SDS_V_STO; // R15
    else if (drive.warning)
      view_nxt = SDS_V_WARN; // R15
    else if (drive.fw_update)
      view_nxt = SDS_V_FWUPD;
    else if (drive.parameter_set_file)
      view_nxt = SDS_V_PFILE;
    else if (not_comm_r)
      view_nxt = SDS_V_NOTCOMM;
    else if (drive.homing)
      view_nxt = SDS_V_HOMING;
    else if (drive.mode == SDS_MODE_SPEED)
      view_nxt = SDS_V_SPEED;
    else if (drive.mode == SDS_MODE_POSITION)
      view_nxt = SDS_V_POSITION;
    else
      view_nxt = SDS_V_TORQUE;
    // Trailing blank marks where a series restarts; the two L stay adjacent
    unique case (view_nxt)
      SDS_V_IDENT:
      begin
        msg[0] = CH_H; // R11
        msg[1] = CH_E;
        msg[2] = CH_L;
        msg[3] = CH_L;
        msg[4] = CH_O;
        msg_len = 3'd6;
      end
      SDS_V_ERROR:
      begin
        msg[0] = CH_E; // R5 R7
        msg[1] = sds_digit(drive.err_tens);
        msg[2] = sds_digit(drive.err_ones);
        msg[3] = sds_digit(drive.err_sub);
        msg_len = 3'd5;
      end
      SDS_V_STO: msg[0] = CH_H; // R10
      SDS_V_WARN:
      begin
        msg[0] = CH_DASH; // R6
        msg[1] = sds_digit(drive.warn_tens);
        msg[2] = sds_digit(drive.warn_ones);
        msg[3] = sds_digit(drive.warn_sub);
        msg[4] = CH_DASH;
        msg_len = 3'd6;
      end
      SDS_V_FWUPD: msg[0] = CH_F; // R12
      SDS_V_PFILE: msg[0] = CH_D; // R12
      SDS_V_NOTCOMM: msg[0] = CH_A; // R8
      SDS_V_HOMING:
      begin
        msg[0] = CH_P; // R3
        msg[1] = CH_H;
        msg[2] = sds_digit({2'b00, drive.homing_phase});
        msg_len = 3'd4;
      end
      SDS_V_POSITION: msg[0] = CH_P;
      SDS_V_TORQUE: msg[0] = CH_T;
      SDS_V_SPEED:
      begin
        // Outer ring a..f, one segment lit per motion step
        unique case (drive.anim_step)
          3'd0, 3'd6: anim_seg = 7'h01; // R1
          3'd1, 3'd7: anim_seg = 7'h02;
          3'd2: anim_seg = 7'h04;
          3'd3: anim_seg = 7'h08;
          3'd4: anim_seg = 7'h10;
          default: anim_seg = 7'h20;
        endcase
        anim_seg[6] = drive.enabled; // R2
      end
      default: msg[0] = CH_BLANK;
    endcase
    // Zero dwell would stall the series; treat it as one cycle
    dwell_eff = (dwell_r == 32'h0000_0000) ? 32'h0000_0001 : dwell_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    if (view_nxt != view_r)
    begin
      idx_nxt = 3'd0;
      cnt_nxt = 32'h0000_0000;
    end
    else if (msg_len > 3'd1)
    begin
      if (cnt_r + 32'h0000_0001 >= dwell_eff)
      begin
        cnt_nxt = 32'h0000_0000; // R16
        idx_nxt = (idx_r + 3'd1 >= msg_len) ? 3'd0 : idx_r + 3'd1; // R4
      end
      else
        cnt_nxt = cnt_r + 32'h0000_0001; // R16
    end
    else
    begin
      idx_nxt = 3'd0; // R10
      cnt_nxt = 32'h0000_0000;
    end
    if (view_nxt == SDS_V_SPEED)
      seg_nxt = anim_seg;
    else
      seg_nxt = sds_glyph(msg[idx_nxt]);
    led_red_nxt = drive.fault; // R13
    led_green_nxt = drive.ready && !drive.fault; // R13
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      view_r <= SDS_V_TORQUE;
      idx_r <= 3'd0;
      cnt_r <= 32'h0000_0000;
      seg_r <= 7'h00;
      led_green_r <= 1'b0;
      led_red_r <= 1'b0;
    end
    else
    begin
      view_r <= view_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      seg_r <= seg_nxt;
      led_green_r <= led_green_nxt;
      led_red_r <= led_red_nxt;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign seg = seg_r;
  assign led_green = led_green_r;
  assign led_red = led_red_r;

endmodule : sds_display
`default_nettype wire

/* File: verification/sds_display_sva.sv */
// Checker for the status display block: bus handshakes and LED colours.
// Bound to sds_display; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sds_display_sva
  import sds_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire sds_drive_t drive,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [6:0] seg,
  input wire logic led_green,
  input wire logic led_red
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // LED halves are registered, so they trail their flags by one edge
  property p_red; $past(aresetn) |-> led_red == $past(drive.fault); endproperty
  property p_green;
    $past(aresetn) |-> led_green == ($past(drive.ready) && !$past(drive.fault));
  endproperty
  // Bus answers one edge after the request is taken
  property p_rone;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0B
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000;
  endproperty
  property p_mapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr inside {8'h00, 8'h04, 8'h08}
      |=> s_axi_rresp == 2'b00;
  endproperty
  property p_awlow; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  property p_arlow; s_axi_rvalid |-> !s_axi_arready; endproperty

  a_red: assert property (p_red)
    else $error("led_red does not follow the fault flag");
  a_green: assert property (p_green)
    else $error("led_green does not follow ready without fault");
  a_rone: assert property (p_rone)
    else $error("read answer not one edge after address");
  a_bdone: assert property (p_bdone)
    else $error("write response not retired after handshake");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused with zero data");
  a_mapped: assert property (p_mapped)
    else $error("mapped read not answered okay");
  a_awlow: assert property (p_awlow)
    else $error("write address ready stays high after take");
  a_arlow: assert property (p_arlow)
    else $error("read address ready high while data pending");

  c_unmapped: cover property (p_unmapped);
  c_red: cover property (led_red);
  c_speed: cover property (drive.mode == SDS_MODE_SPEED && seg[6]);
endmodule : sds_display_sva

bind sds_display sds_display_sva #(.ADDR_W(ADDR_W)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .drive(drive),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .seg(seg),
  .led_green(led_green), .led_red(led_red));
`default_nettype wire

/* File: verification/sds_panel.sv */
// Model of the digit and the two-colour LED: decodes what is lit.
// Assumes segment bit0 = a .. bit6 = g, active high.
`timescale 1ns/1ps
`default_nettype none
module sds_panel (
  input wire logic [6:0] seg,
  input wire logic led_green,
  input wire logic led_red,
  output logic [3:0] glyph,
  output logic [1:0] colour
);
  // Digits 0 to 5 decoded, the letter O as 0; other letters and digits 6 to 9 only as lit, since their shapes are free
  always_comb
  begin
    case (seg)
      7'h3F: glyph = 4'h0;
      7'h06: glyph = 4'h1;
      7'h5B: glyph = 4'h2;
      7'h4F: glyph = 4'h3;
      7'h66: glyph = 4'h4;
      7'h6D: glyph = 4'h5;
      7'h00: glyph = 4'hF;
      default: glyph = 4'hE;
    endcase
    colour = {led_red, led_green};
  end
endmodule : sds_panel
`default_nettype wire

/* File: verification/sds_display_tb_top.sv */
// Bench for the status display: bus tasks plus message sequences.
// Assumes DWELL_RESET 4 and IDENT_CYCLES 20 to keep the run short.
`timescale 1ns/1ps
`default_nettype none
`include "sds_consts.svh"
`define CHK(nm, e, a) \
  begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, a); end end
module sds_display_tb_top
  import sds_pkg::*;
;
  localparam int DW = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic comm_st = 1'b0;
  sds_drive_t drv = '0;
  sds_drive_t base = '0;
  sds_drive_t v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, d;
  logic [1:0] bresp, rresp, colour, r;
  logic awready, wready, bvalid, arready, rvalid, led_g, led_r;
  logic [6:0] seg, s1;
  logic [5:0] mask;
  logic [3:0] glyph;
  int n_fail = 0;
  int n_checks = 0;
  int t;

  sds_display #(.IDENT_CYCLES(32'h0000_0014), .DWELL_RESET(32'(DW))) dut (
    .aclk(aclk), .aresetn(aresetn), .drive(drv), .commissioned_stored(comm_st),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .seg(seg), .led_green(led_g), .led_red(led_r));
  sds_panel panel (.seg(seg), .led_green(led_g), .led_red(led_r),
    .glyph(glyph), .colour(colour));

  // Free-running 10 MHz clock
  initial
  begin
    forever #50 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic tmo;
    n_fail++;
    $display("Error handshake expected answer seen none");
    end_sim();
  endtask : tmo

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] wd,
                     output logic [1:0] rs);
    int k;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= wd;
    bready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 40) tmo();
    rs = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] rd,
                     output logic [1:0] rs);
    int k;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 40) tmo();
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr

  // Later resets, with the stored commissioning state picked by the test
  task automatic rst(input logic cs);
    comm_st <= cs;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : rst

  // Steady base view first, so the first change marks character 0
  task automatic go(input sds_drive_t w);
    @(posedge aclk);
    drv <= base;
    repeat (3) @(posedge aclk);
    drv <= w;
  endtask : go

  // Samples each character mid-dwell; 4'hD accepts any lit glyph
  task automatic msg(input string nm, input logic [3:0] e [6], input int n);
    logic [6:0] old;
    logic [3:0] g;
    int k;
    old = seg;
    for (k = 0; k < 20 && seg === old; k++)
    begin
      @(posedge aclk);
      #1;
    end
    if (seg === old) tmo();
    repeat (2) @(posedge aclk);
    for (int i = 0; i < n; i++)
    begin
      #1;
      g = (e[i] == 4'hD && glyph !== 4'hF) ? 4'hD : glyph;
      `CHK(nm, e[i], g);
      repeat (DW) @(posedge aclk);
    end
  endtask : msg

  initial
  begin
    base.ready = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(`SDS_REG_STATUS, d, r);
    `CHK("not_comm_set", 1'b1, d[`SDS_ST_NOT_COMM]);
    `CHK("letter_a", 4'hE, glyph);
    axr(`SDS_REG_DWELL, d, r);
    `CHK("dwell_reset", 32'(DW), d);
    `CHK("dwell_resp", `SDS_RESP_OKAY, r);
    axr(8'h0C, d, r);
    `CHK("unmapped_rd", `SDS_RESP_SLVERR, r);
    axw(8'h0C, 32'h0000_0001, r);
    `CHK("unmapped_wr", `SDS_RESP_SLVERR, r);
    axw(`SDS_REG_DWELL, 32'h0000_0006, r);
    axr(`SDS_REG_DWELL, d, r);
    `CHK("dwell_write", 32'h0000_0006, d);
    axw(`SDS_REG_DWELL, 32'(DW), r);
    s1 = seg;
    axw(`SDS_REG_CTRL, 32'h0000_0004, r);
    axr(`SDS_REG_STATUS, d, r);
    `CHK("not_comm_clr", 1'b0, d[`SDS_ST_NOT_COMM]);
    `CHK("letter_a_gone", 1'b1, seg !== s1);
    $display("test registers done");
    // Message views, each entered from the steady torque glyph
    v = base;
    v.fault = 1'b1;
    v.err_tens = 4'h1;
    v.err_ones = 4'h2;
    v.err_sub = 4'h3;
    go(v);
    msg("error", '{4'hE, 4'h1, 4'h2, 4'h3, 4'hF, 4'hF}, 5);
    `CHK("led_red", 2'b10, colour);
    v = base;
    v.warning = 1'b1;
    v.warn_tens = 4'h2;
    v.warn_ones = 4'h5;
    v.warn_sub = 4'h4;
    go(v);
    msg("warning", '{4'hE, 4'h2, 4'h5, 4'h4, 4'hE, 4'hF}, 6);
    `CHK("led_green", 2'b01, colour);
    v.safe_torque_off_input = 1'b1;
    go(v);
    msg("sto", '{4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE}, 6);
    for (int p = 0; p < 3; p++)
    begin
      v = base;
      v.homing = 1'b1;
      v.homing_phase = p[1:0];
      go(v);
      msg("homing", '{4'hE, 4'hE, p[3:0], 4'hF, 4'hF, 4'hF}, 4);
    end
    $display("test messages done");
    v = base;
    v.fw_update = 1'b1;
    go(v);
    repeat (3) @(posedge aclk);
    s1 = seg;
    v = base;
    v.parameter_set_file = 1'b1;
    go(v);
    repeat (3) @(posedge aclk);
    `CHK("fw_vs_file", 1'b1, s1 !== seg && seg !== 7'h00 && s1 !== 7'h00);
    // Rotation: one outer segment per step, centre tracks enable
    v = base;
    v.mode = SDS_MODE_SPEED;
    v.enabled = 1'b1;
    mask = 6'h00;
    for (int k = 0; k < 6; k++)
    begin
      v.anim_step = k[2:0];
      go(v);
      repeat (2) @(posedge aclk);
      #1;
      `CHK("one_outer", 1'b1, $countones(seg[5:0]) == 1);
      `CHK("centre_on", 1'b1, seg[6]);
      mask = mask | seg[5:0];
    end
    `CHK("rotation", 6'h3F, mask);
    v.enabled = 1'b0;
    go(v);
    repeat (2) @(posedge aclk);
    #1;
    `CHK("centre_off", 1'b0, seg[6]);
    $display("test speed done");
    // Identify held over a fault; sync on the blank ending a word
    v = base;
    v.fault = 1'b1;
    go(v);
    axw(`SDS_REG_CTRL, 32'h0000_0001, r);
    repeat (2) @(posedge aclk);
    for (t = 0; t < 40 && glyph !== 4'hF; t++)
    begin
      @(posedge aclk);
      #1;
    end
    if (glyph !== 4'hF) tmo();
    msg("identify", '{4'hD, 4'hD, 4'hD, 4'hD, 4'hD, 4'hF}, 6);
    axw(`SDS_REG_CTRL, 32'h0000_0000, r);
    axw(`SDS_REG_CTRL, 32'h0000_0002, r);
    axr(`SDS_REG_STATUS, d, r);
    `CHK("ident_timed", 1'b1, d[`SDS_ST_IDENT]);
    repeat (30) @(posedge aclk);
    axr(`SDS_REG_STATUS, d, r);
    `CHK("ident_expired", 1'b0, d[`SDS_ST_IDENT]);
    axw(`SDS_REG_CTRL, 32'h0000_0002, r);
    axw(`SDS_REG_CTRL, 32'h0000_0008, r);
    axr(`SDS_REG_STATUS, d, r);
    `CHK("ident_cancel", 1'b0, d[`SDS_ST_IDENT]);
    $display("test identify done");
    // Stored state after a reset, then a drive parameter change clears A
    rst(1'b1);
    axr(`SDS_REG_STATUS, d, r);
    `CHK("stored_comm", 1'b0, d[`SDS_ST_NOT_COMM]);
    rst(1'b0);
    axr(`SDS_REG_STATUS, d, r);
    `CHK("delivery_again", 1'b1, d[`SDS_ST_NOT_COMM]);
    v = base;
    v.param_changed = 1'b1;
    go(v);
    @(posedge aclk);
    drv <= base;
    axr(`SDS_REG_STATUS, d, r);
    `CHK("param_clears", 1'b0, d[`SDS_ST_NOT_COMM]);
    $display("test resets done");
    end_sim();
  end
endmodule : sds_display_tb_top
`default_nettype wire
